// ---- verilog/backlight_regs.vh ----
`ifndef BACKLIGHT_REGS_VH
`define BACKLIGHT_REGS_VH

// ===========================================================
// Register offsets
`define OFS_PWM_BRIGHTNESS 8'h00
`define OFS_DEVICE_CONTROL 8'h01
`define OFS_FAULT_AND_STATE 8'h02
`define OFS_IDENTIFICATION 8'h03
`define OFS_DC_BRIGHTNESS 8'h07
`define OFS_CONFIGURATION 8'h08

// ===========================================================
// Field positions
`define CTL_BACKLIGHT_ON 0
`define CTL_SOURCE_EXT 1
`define CTL_INTERPRET 2
`define STS_FAULT 0
`define STS_THERMAL 1
`define STS_OVERCURRENT 2
`define STS_BACKLIGHT 3
`define STS_ONE_DOWN 4
`define STS_TWO_DOWN 5
`define CFG_SHORT_EN 1
`define CFG_SHORT_HIGH 0
`define CFG_FREQ_HIGH 2
`define ID_PANEL 7

// ===========================================================
// Reset values
`define RST_PWM_BRIGHTNESS 8'hFF
`define RST_DEVICE_CONTROL 3'h0
`define RST_FAULT 1'b0
`define RST_DC_BRIGHTNESS 8'hFF
`define RST_CONFIGURATION 8'hFF
`define READ_UNMAPPED 8'h00

// ===========================================================
// Identification, arbitrary values
`define VENDOR_NOT_IMPLEMENTED 4'hF
`define SILICON_REVISION 3'h0
`define SMBUS_ADDRESS 7'h2C

// ===========================================================
// Timing counts
`define PWM_SAMPLE_DIV 8'h04
`define PWM_WINDOW_LAST 8'hFE

`endif

// ---- verilog/two_stage_sync.v ----
`timescale 1ns/1ns
`default_nettype none

module two_stage_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] first_stage;

always @(posedge core_clk) begin
    if (rst) begin
        first_stage <= INIT;
        sync_out <= INIT;
    end else begin
        first_stage <= async_in;
        sync_out <= first_stage;
    end
end

endmodule

`default_nettype wire

// ---- verilog/led_backlight_ctrl_status_regs.v ----
`timescale 1ns/1ns
`default_nettype none
`include "backlight_regs.vh"

module led_backlight_ctrl_status_regs #(
    parameter [6:0] SMBUS_ADDR = `SMBUS_ADDRESS,
    parameter [3:0] VENDOR_CODE = `VENDOR_NOT_IMPLEMENTED,
    parameter [2:0] SILICON_REV = `SILICON_REVISION
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // SMBus pins
    input wire smb_clk_in,
    input wire smb_data_in,
    output wire smb_data_out,
    output reg smb_data_oe,
    // Fault, supply and external PWM inputs
    input wire thermal_fault_in,
    input wire input_overcurrent_in,
    input wire [7:0] channel_down_in,
    input wire backlight_supply_rail,
    input wire external_pwm_input,
    // Controls to the power stage
    output wire backlight_on_cmd,
    output wire dim_interpret_sel,
    output wire dim_source_ext,
    output reg [7:0] brightness_level,
    output reg [7:0] dc_level,
    output wire [1:0] short_threshold_sel,
    output wire short_detect_en,
    output wire short_threshold_high,
    output wire boost_freq_high,
    // Status
    output wire backlight_on_state,
    output wire fault_flag
);

// ===========================================================
// Input synchronisers
localparam ST_IDLE = 3'd0;
localparam ST_RX = 3'd1;
localparam ST_ACK = 3'd2;
localparam ST_TX = 3'd3;
localparam ST_TXACK = 3'd4;
localparam KIND_ADDR = 2'd0;
localparam KIND_CMD = 2'd1;
localparam KIND_DATA = 2'd2;

wire [1:0] bus_s;
wire [11:0] misc_s;
wire scl_s = bus_s[1];
wire sda_s = bus_s[0];
wire thermal_s = misc_s[11];
wire overcurrent_s = misc_s[10];
wire rail_s = misc_s[9];
wire pwm_s = misc_s[8];
wire [7:0] chan_s = misc_s[7:0];

two_stage_sync #(.WIDTH(2), .INIT(2'b11)) u_bus_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({smb_clk_in, smb_data_in}),
    .sync_out(bus_s)
);

two_stage_sync #(.WIDTH(12), .INIT(12'h000)) u_misc_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({thermal_fault_in, input_overcurrent_in,
               backlight_supply_rail, external_pwm_input,
               channel_down_in}),
    .sync_out(misc_s)
);

// ===========================================================
// Bus edge and condition detection
reg scl_d;
reg sda_d;
wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

always @(posedge core_clk) begin
    if (rst) begin
        scl_d <= 1'b1;
        sda_d <= 1'b1;
    end else begin
        scl_d <= scl_s;
        sda_d <= sda_s;
    end
end

// ===========================================================
// Register state
reg [2:0] control;
reg [7:0] pwm_setting;
reg [7:0] configuration;
reg fault_sticky;
reg [7:0] duty_meas;
reg [7:0] read_data;
reg wr_stb;
reg [7:0] wr_addr;
reg [7:0] wr_data;

wire mode_ext = control[`CTL_SOURCE_EXT];
wire mode_smbus = ~control[`CTL_SOURCE_EXT] & control[`CTL_INTERPRET];
wire mode_scaled = ~control[`CTL_SOURCE_EXT] & ~control[`CTL_INTERPRET];

assign backlight_on_cmd = control[`CTL_BACKLIGHT_ON];
assign dim_interpret_sel = control[`CTL_INTERPRET];
assign dim_source_ext = control[`CTL_SOURCE_EXT];
assign short_threshold_sel = configuration[1:0];
assign short_detect_en = configuration[`CFG_SHORT_EN];
assign short_threshold_high = configuration[`CFG_SHORT_HIGH];
assign boost_freq_high = configuration[`CFG_FREQ_HIGH];

// ===========================================================
// Status evaluation
reg [3:0] down_count;
integer i;

always @* begin
    down_count = 4'h0;
    for (i = 0; i < 8; i = i + 1) begin
        down_count = down_count + {3'b000, chan_s[i]};
    end
end

// Channel faults only count while lit and supplied
assign backlight_on_state = control[`CTL_BACKLIGHT_ON] & rail_s;
wire one_down = backlight_on_state & (down_count != 4'h0);
wire two_down = backlight_on_state & (down_count > 4'h1);
wire thermal_now = thermal_s;
wire overcurrent_now = overcurrent_s & rail_s;
wire fault_cause = thermal_now | overcurrent_now | one_down | two_down;
assign fault_flag = fault_sticky;

wire [7:0] status_byte = {2'b00, two_down, one_down, backlight_on_state,
                          overcurrent_now, thermal_now, fault_sticky};
wire [7:0] id_byte = {1'b1, VENDOR_CODE, SILICON_REV};

wire wr_ctl = wr_stb & (wr_addr == `OFS_DEVICE_CONTROL);
wire wr_sts = wr_stb & (wr_addr == `OFS_FAULT_AND_STATE);
wire toggle_on = wr_ctl &
    (wr_data[`CTL_BACKLIGHT_ON] != control[`CTL_BACKLIGHT_ON]);
wire fault_clear = toggle_on | (wr_sts & ~wr_data[`STS_FAULT]);

// Set wins over clear
always @(posedge core_clk) begin
    if (rst) begin
        fault_sticky <= `RST_FAULT;
    end else begin
        fault_sticky <= fault_cause | (fault_sticky & ~fault_clear);
    end
end

// ===========================================================
// External PWM duty measurement
reg [7:0] pre_count;
reg [7:0] sample_count;
reg [7:0] high_count;

always @(posedge core_clk) begin
    if (rst) begin
        pre_count <= 8'h00;
        sample_count <= 8'h00;
        high_count <= 8'h00;
        duty_meas <= 8'h00;
    end else if (pre_count == `PWM_SAMPLE_DIV - 8'h01) begin
        pre_count <= 8'h00;
        if (sample_count == `PWM_WINDOW_LAST) begin
            sample_count <= 8'h00;
            high_count <= 8'h00;
            duty_meas <= high_count + {7'h00, pwm_s};
        end else begin
            sample_count <= sample_count + 8'h01;
            high_count <= high_count + {7'h00, pwm_s};
        end
    end else begin
        pre_count <= pre_count + 8'h01;
    end
end

// ===========================================================
// Register writes and effective brightness
wire [15:0] product = pwm_setting * duty_meas;
wire [16:0] scaled_sum = {1'b0, product} + {9'h000, pwm_setting};
wire [7:0] scaled_level = scaled_sum[15:8];

always @(posedge core_clk) begin
    if (rst) begin
        control <= `RST_DEVICE_CONTROL;
        pwm_setting <= `RST_PWM_BRIGHTNESS;
        dc_level <= `RST_DC_BRIGHTNESS;
        configuration <= `RST_CONFIGURATION;
        brightness_level <= `RST_PWM_BRIGHTNESS;
    end else begin
        if (wr_ctl) begin
            control <= wr_data[2:0];
        end
        if (wr_stb && wr_addr == `OFS_DC_BRIGHTNESS) begin
            dc_level <= wr_data;
        end
        if (wr_stb && wr_addr == `OFS_CONFIGURATION) begin
            configuration <= wr_data;
        end
        if (wr_stb && wr_addr == `OFS_PWM_BRIGHTNESS && !mode_ext) begin
            pwm_setting <= wr_data;
        end
        if (mode_ext) begin
            brightness_level <= duty_meas;
        end else if (mode_scaled) begin
            brightness_level <= scaled_level;
        end else if (wr_stb && wr_addr == `OFS_PWM_BRIGHTNESS) begin
            brightness_level <= wr_data;
        end
    end
end

// ===========================================================
// Read data selection
always @* begin
    case (wr_addr)
        `OFS_PWM_BRIGHTNESS: begin
            if (mode_ext) begin
                read_data = brightness_level;
            end else begin
                read_data = pwm_setting;
            end
        end
        `OFS_DEVICE_CONTROL: read_data = {5'h00, control};
        `OFS_FAULT_AND_STATE: read_data = status_byte;
        `OFS_IDENTIFICATION: read_data = id_byte;
        `OFS_DC_BRIGHTNESS: read_data = dc_level;
        `OFS_CONFIGURATION: read_data = configuration;
        default: read_data = `READ_UNMAPPED;
    endcase
end

// ===========================================================
// SMBus byte read and byte write slave
reg [2:0] state;
reg [1:0] kind;
reg [2:0] bit_count;
reg byte_done;
reg read_mode;
reg [7:0] shift_in;
reg [7:0] shift_out;

assign smb_data_out = 1'b0;

always @(posedge core_clk) begin
    if (rst) begin
        state <= ST_IDLE;
        kind <= KIND_ADDR;
        bit_count <= 3'h0;
        byte_done <= 1'b0;
        read_mode <= 1'b0;
        shift_in <= 8'h00;
        shift_out <= 8'h00;
        smb_data_oe <= 1'b0;
        wr_stb <= 1'b0;
        wr_addr <= 8'h00;
        wr_data <= 8'h00;
    end else begin
        wr_stb <= 1'b0;
        if (start_cond) begin
            state <= ST_RX;
            kind <= KIND_ADDR;
            bit_count <= 3'h0;
            byte_done <= 1'b0;
            read_mode <= 1'b0;
            smb_data_oe <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            smb_data_oe <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    smb_data_oe <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_in <= {shift_in[6:0], sda_s};
                        bit_count <= bit_count + 3'h1;
                        byte_done <= (bit_count == 3'h7);
                    end else if (scl_fall && byte_done) begin
                        byte_done <= 1'b0;
                        state <= ST_ACK;
                        smb_data_oe <= 1'b1;
                        case (kind)
                            KIND_ADDR: begin
                                if (shift_in[7:1] == SMBUS_ADDR) begin
                                    read_mode <= shift_in[0];
                                end else begin
                                    state <= ST_IDLE;
                                    smb_data_oe <= 1'b0;
                                end
                            end
                            KIND_CMD: begin
                                wr_addr <= shift_in;
                            end
                            default: begin
                                wr_data <= shift_in;
                                wr_stb <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_count <= 3'h0;
                        if (read_mode) begin
                            state <= ST_TX;
                            shift_out <= {read_data[6:0], 1'b0};
                            smb_data_oe <= ~read_data[7];
                        end else begin
                            state <= ST_RX;
                            smb_data_oe <= 1'b0;
                            if (kind == KIND_ADDR) begin
                                kind <= KIND_CMD;
                            end else begin
                                kind <= KIND_DATA;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_count <= bit_count + 3'h1;
                        if (bit_count == 3'h7) begin
                            state <= ST_TXACK;
                            smb_data_oe <= 1'b0;
                        end else begin
                            smb_data_oe <= ~shift_out[7];
                            shift_out <= {shift_out[6:0], 1'b0};
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_ACK;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    smb_data_oe <= 1'b0;
                end
            endcase
        end
    end
end

endmodule

`default_nettype wire

// ---- test/backlight_regs_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Port checks
module backlight_regs_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Inputs
    input wire logic smb_clk_in,
    input wire logic thermal_fault_in,
    input wire logic input_overcurrent_in,
    input wire logic [7:0] channel_down_in,
    input wire logic backlight_supply_rail,
    // Outputs
    input wire logic backlight_on_cmd,
    input wire logic dim_interpret_sel,
    input wire logic dim_source_ext,
    input wire logic [7:0] brightness_level,
    input wire logic [7:0] dc_level,
    input wire logic [1:0] short_threshold_sel,
    input wire logic short_detect_en,
    input wire logic short_threshold_high,
    input wire logic boost_freq_high,
    input wire logic backlight_on_state,
    input wire logic fault_flag
);
    logic [3:0] quiet;
    logic cause;
    assign cause = thermal_fault_in | input_overcurrent_in
        | (|channel_down_in);
    // Cycles since any raw fault cause
    always @(posedge core_clk) begin
        if (rst || cause) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_lit;
        (backlight_on_cmd && backlight_supply_rail) [*4];
    endsequence
    sequence s_chan;
        ((|channel_down_in) && backlight_on_state) [*3];
    endsequence
    a_reset_vals: assert property ($past(rst) |->
        !backlight_on_cmd && !dim_interpret_sel && !dim_source_ext
        && dc_level == 8'hFF && short_threshold_sel == 2'h3
        && boost_freq_high && !fault_flag) else $error("reset value");
    a_state_on: assert property (s_lit |-> backlight_on_state)
        else $error("state low");
    a_rail_off: assert property (
        !backlight_supply_rail [*4] |-> !backlight_on_state)
        else $error("state high");
    a_short_decode: assert property (
        short_detect_en == short_threshold_sel[1]
        && short_threshold_high == short_threshold_sel[0])
        else $error("short decode");
    a_thermal_sets: assert property (
        thermal_fault_in |-> ##[1:5] fault_flag) else $error("no fault");
    a_chan_sets: assert property (s_chan |-> ##[0:4] fault_flag)
        else $error("no fault");
    a_fault_cause: assert property (
        $rose(fault_flag) |-> quiet < 4'h6) else $error("no cause");
    a_toggle_clear: assert property (
        $changed(backlight_on_cmd) && quiet == 4'hF |-> ##[0:2] !fault_flag)
        else $error("fault kept");
    a_abs_hold: assert property (
        !dim_source_ext && dim_interpret_sel && $stable(dim_interpret_sel)
        && $stable(dim_source_ext) && $changed(brightness_level)
        |-> !smb_clk_in) else $error("level moved");
endmodule
`default_nettype wire

// ---- test/smbus_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Bus master, 160 ns bit period
module smbus_host_model #(
    parameter logic [6:0] ADDR = 7'h2C
) (
    // Clock
    input wire logic core_clk,
    // Bus lines
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    int ack_errs = 0;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Data moves only while the clock is low
    task automatic put(input logic b, output logic r);
        wt(2);
        sda_pull = ~b;
        wt(6);
        scl = 1'b1;
        wt(8);
        r = sda_wire;
        scl = 1'b0;
    endtask
    task automatic start();
        wt(2);
        sda_pull = 1'b0;
        wt(6);
        scl = 1'b1;
        wt(8);
        sda_pull = 1'b1;
        wt(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        wt(2);
        sda_pull = 1'b1;
        wt(6);
        scl = 1'b1;
        wt(8);
        sda_pull = 1'b0;
        wt(8);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ea,
        output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put(d[i], r[i]);
        end
        put(1'b1, a);
        if (a !== ea) begin
            ack_errs++;
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, v);
        logic [7:0] r;
        logic e;
        e = (a != ADDR);
        start();
        xfer({a, 1'b0}, e, r);
        xfer(o, e, r);
        xfer(v, e, r);
        stop();
    endtask
    task automatic rd(input logic [7:0] o, output logic [7:0] v);
        logic [7:0] r;
        start();
        xfer({ADDR, 1'b0}, 1'b0, r);
        xfer(o, 1'b0, r);
        start();
        xfer({ADDR, 1'b1}, 1'b0, r);
        xfer(8'hFF, 1'b1, v);
        stop();
    endtask
endmodule
`default_nettype wire

// ---- test/led_backlight_ctrl_status_regs_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("MISMATCH %s expected %h seen %h", n, e, g); \
    end \
end
module led_backlight_ctrl_status_regs_test;
    localparam logic [6:0] DEV = 7'h2C; // Arbitrary
    localparam logic [3:0] VEND = 4'hF;
    localparam logic [2:0] REV = 3'h2; // Arbitrary
    // ========================================
    // Signals
    logic core_clk, rst, scl, sda_pull, thermal_fault_in;
    logic input_overcurrent_in, backlight_supply_rail, external_pwm_input;
    logic [7:0] channel_down_in;
    wire smb_data_oe, backlight_on_cmd, dim_interpret_sel, dim_source_ext;
    wire short_detect_en, short_threshold_high, boost_freq_high;
    wire backlight_on_state, fault_flag, sda_wire;
    wire [7:0] brightness_level, dc_level;
    wire [1:0] short_threshold_sel;
    int err_count = 0;
    int samples_checked = 0;
    assign sda_wire = ~(smb_data_oe | sda_pull);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    led_backlight_ctrl_status_regs #(.SMBUS_ADDR(DEV), .VENDOR_CODE(VEND),
        .SILICON_REV(REV)) led_backlight_ctrl_status_regs_inst (
        .core_clk(core_clk), .rst(rst), .smb_clk_in(scl),
        .smb_data_in(sda_wire), .smb_data_out(), .smb_data_oe(smb_data_oe),
        .thermal_fault_in(thermal_fault_in),
        .input_overcurrent_in(input_overcurrent_in),
        .channel_down_in(channel_down_in),
        .backlight_supply_rail(backlight_supply_rail),
        .external_pwm_input(external_pwm_input),
        .backlight_on_cmd(backlight_on_cmd),
        .dim_interpret_sel(dim_interpret_sel),
        .dim_source_ext(dim_source_ext),
        .brightness_level(brightness_level), .dc_level(dc_level),
        .short_threshold_sel(short_threshold_sel),
        .short_detect_en(short_detect_en),
        .short_threshold_high(short_threshold_high),
        .boost_freq_high(boost_freq_high),
        .backlight_on_state(backlight_on_state), .fault_flag(fault_flag));
    smbus_host_model #(.ADDR(DEV)) smbus_host_model_inst (
        .core_clk(core_clk), .sda_wire(sda_wire), .scl(scl),
        .sda_pull(sda_pull));
    // ========================================
    // Helpers
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic w(input logic [7:0] o, v);
        smbus_host_model_inst.wr(DEV, o, v);
    endtask
    task automatic rc(input logic [7:0] o, e);
        logic [7:0] v;
        smbus_host_model_inst.rd(o, v);
        `CHK("register read", e, v)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        rc(8'h01, 8'h00);
        rc(8'h02, 8'h00);
        w(8'h03, 8'h00);
        rc(8'h03, {1'b1, VEND, REV});
        rc(8'h07, 8'hFF);
        rc(8'h08, 8'hFF);
        rc(8'h05, 8'h00);
        $display("done reset values");
    endtask
    task automatic t_control();
        logic [7:0] v;
        for (int i = 0; i < 3; i++) begin
            v = 8'h01 << i;
            w(8'h01, v | 8'hF8);
            rc(8'h01, v);
            `CHK("on", v[0], backlight_on_cmd)
            `CHK("source", v[1], dim_source_ext)
            `CHK("interpret", v[2], dim_interpret_sel)
        end
        w(8'h01, 8'h00);
        $display("done control");
    endtask
    task automatic t_config();
        logic [7:0] c [3] = '{8'h00, 8'h05, 8'h06};
        foreach (c[i]) begin
            w(8'h08, c[i]);
            rc(8'h08, c[i]);
            `CHK("short on", c[i][1], short_detect_en)
            `CHK("short hi", c[i][0], short_threshold_high)
            `CHK("freq", c[i][2], boost_freq_high)
        end
        w(8'h08, 8'hFF);
        $display("done config");
    endtask
    task automatic t_dim();
        w(8'h07, 8'h3C);
        `CHK("dc", 8'h3C, dc_level)
        smbus_host_model_inst.wr(7'h2D, 8'h07, 8'h11);
        rc(8'h07, 8'h3C);
        `CHK("acks", 0, smbus_host_model_inst.ack_errs)
        w(8'h01, 8'h04);
        w(8'h00, 8'h5A);
        `CHK("level", 8'h5A, brightness_level)
        w(8'h01, 8'h00);
        wt(2200);
        `CHK("scaled", 8'h00, brightness_level)
        rc(8'h00, 8'h5A);
        external_pwm_input = 1'b1;
        w(8'h01, 8'h02);
        wt(2200);
        `CHK("external", 8'hFF, brightness_level)
        rc(8'h00, 8'hFF);
        w(8'h01, 8'h04);
        external_pwm_input = 1'b0;
        wt(2200);
        `CHK("held", 8'hFF, brightness_level)
        $display("done dimming");
    endtask
    task automatic t_status();
        w(8'h01, 8'h01);
        rc(8'h02, 8'h08);
        thermal_fault_in = 1'b1;
        rc(8'h02, 8'h0B);
        w(8'h02, 8'hFE);
        rc(8'h02, 8'h0B);
        thermal_fault_in = 1'b0;
        rc(8'h02, 8'h09);
        w(8'h02, 8'hFE);
        rc(8'h02, 8'h08);
        channel_down_in = 8'h10;
        rc(8'h02, 8'h19);
        channel_down_in = 8'h81;
        rc(8'h02, 8'h39);
        channel_down_in = 8'h00;
        w(8'h01, 8'h00);
        rc(8'h02, 8'h00);
        input_overcurrent_in = 1'b1;
        rc(8'h02, 8'h05);
        input_overcurrent_in = 1'b0;
        w(8'h02, 8'h00);
        rc(8'h02, 8'h00);
        w(8'h01, 8'h01);
        w(8'h01, 8'h00);
        rc(8'h02, 8'h00);
        backlight_supply_rail = 1'b0;
        channel_down_in = 8'hFF;
        w(8'h01, 8'h01);
        rc(8'h02, 8'h00);
        `CHK("state", 1'b0, backlight_on_state)
        $display("done status");
    endtask
    // ========================================
    // Main sequence and watchdog
    initial begin
        rst = 1'b1;
        thermal_fault_in = 1'b0;
        input_overcurrent_in = 1'b0;
        backlight_supply_rail = 1'b1;
        external_pwm_input = 1'b0;
        channel_down_in = 8'h00;
        wt(6);
        rst = 1'b0;
        wt(4);
        t_reset();
        t_control();
        t_config();
        t_dim();
        t_status();
        report_and_stop();
    end
    initial begin
        #700000;
        err_count++;
        $display("MISMATCH watchdog expected done seen timeout");
        report_and_stop();
    end
endmodule
bind led_backlight_ctrl_status_regs backlight_regs_checker checker_inst (
    .core_clk(core_clk), .rst(rst), .smb_clk_in(smb_clk_in),
    .thermal_fault_in(thermal_fault_in),
    .input_overcurrent_in(input_overcurrent_in),
    .channel_down_in(channel_down_in),
    .backlight_supply_rail(backlight_supply_rail),
    .backlight_on_cmd(backlight_on_cmd),
    .dim_interpret_sel(dim_interpret_sel), .dim_source_ext(dim_source_ext),
    .brightness_level(brightness_level), .dc_level(dc_level),
    .short_threshold_sel(short_threshold_sel),
    .short_detect_en(short_detect_en),
    .short_threshold_high(short_threshold_high),
    .boost_freq_high(boost_freq_high),
    .backlight_on_state(backlight_on_state), .fault_flag(fault_flag));
`default_nettype wire
